// ==== hdl/pfcs_pkg.sv ====
// Behaviour
// - reading needs chip select and output gate both low; flash drives the byte.
// - host never erases before programming; programming over cleared bits fails verify.
// - byte program is three unlock writes then one address and data write.
// - sector erase is six writes, the last carrying 30H and a 4 KByte sector.
// - after a stable status result, reread twice more before accepting completion.
// - program unlock is AAH at 5555H, 55H at 2AAAH, A0H at 5555H.
package pfcs_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int SECTOR_LSB = 12;
  localparam logic [14:0] UNLOCK_ADDR1 = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR2 = 15'h2aaa;
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'ha0;
  localparam logic [7:0] CODE_ERASE = 8'h80;
  localparam logic [7:0] CODE_SECTOR = 8'h30;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
  localparam logic [7:0] CODE_ID_EXIT = 8'hf0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int POLARITY_BIT = 7;
  localparam int TOGGLE_BIT = 6;

  // timing at the 25 MHz system clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int WE_LOW_NS = 80;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_NS = 70;
  localparam int SYNC_STAGES = 2;
  localparam int RD_WAIT_CYC =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int PROG_MAX_US = 20;
  localparam int PROG_TIMEOUT_CYC = PROG_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int SETTLE_US = 1;
  localparam int SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_MAX_MS = 100;
  localparam int ERASE_TIMEOUT_CYC = ERASE_MAX_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POLL_CONFIRM = 3;
  localparam int CNT_W = 5;
  localparam int TIMER_W = 32;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_SECTOR_ERASE = 3'h2,
    OP_CHIP_ERASE = 3'h3,
    OP_ID_ENTRY = 3'h4,
    OP_ID_EXIT = 3'h5,
    OP_ID_EXIT_LONG = 3'h6
  } pfcs_op_t;

  // gray codes along idle, write, read, settle
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WSET = 3'h1,
    ST_WLOW = 3'h3,
    ST_WREL = 3'h2,
    ST_RLOW = 3'h6,
    ST_RREL = 3'h7,
    ST_SETTLE = 3'h5
  } pfcs_state_t;

  typedef enum logic [1:0] {
    RD_USER = 2'h0,
    RD_POLL = 2'h1,
    RD_FINAL = 2'h2
  } pfcs_rdkind_t;

  // number of bus writes for each operation
  function automatic logic [2:0] pfcs_seq_len(input pfcs_op_t op);
    case (op)
      OP_PROGRAM: return 3'h4;
      OP_SECTOR_ERASE, OP_CHIP_ERASE: return 3'h6;
      OP_ID_ENTRY, OP_ID_EXIT_LONG: return 3'h3;
      OP_ID_EXIT: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction : pfcs_seq_len

  // address and data of write idx; upper address lines are zero in unlock writes
  function automatic logic [ADDR_W+DATA_W-1:0] pfcs_seq_word(input pfcs_op_t op,
      input logic [2:0] idx, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] u1;
    logic [ADDR_W-1:0] u2;
    u1 = {4'h0, UNLOCK_ADDR1};
    u2 = {4'h0, UNLOCK_ADDR2};
    case (idx)
      3'h0: return (op == OP_ID_EXIT) ? {a, CODE_ID_EXIT} : {u1, CODE_UNLOCK1};
      3'h1: return {u2, CODE_UNLOCK2};
      3'h2: begin
        case (op)
          OP_PROGRAM: return {u1, CODE_PROGRAM};
          OP_ID_ENTRY: return {u1, CODE_ID_ENTRY};
          OP_ID_EXIT_LONG: return {u1, CODE_ID_EXIT};
          default: return {u1, CODE_ERASE};
        endcase
      end
      3'h3: return (op == OP_PROGRAM) ? {a, d} : {u1, CODE_UNLOCK1};
      3'h4: return {u2, CODE_UNLOCK2};
      default: begin
        if (op == OP_SECTOR_ERASE) begin
          return {a[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}, CODE_SECTOR};
        end
        return {u1, CODE_CHIP};
      end
    endcase
  endfunction : pfcs_seq_word

endpackage : pfcs_pkg

// ==== hdl/pfcs_host.sv ====
`timescale 1ns/100ps
module pfcs_host #(
  parameter int EraseTimeoutCyc = pfcs_pkg::ERASE_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmdValid,
  input wire logic [2:0] cmdOp,
  input wire logic [18:0] cmdAddr,
  input wire logic [7:0] cmdData,
  output logic cmdReady,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspError,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [18:0] flashAddr,
  output logic [7:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [7:0] flashDqIn
);

  pfcs_pkg::pfcs_state_t stateQ;
  pfcs_pkg::pfcs_op_t opQ;
  pfcs_pkg::pfcs_rdkind_t rdKindQ;
  logic [18:0] addrQ;
  logic [7:0] dataQ;
  logic [2:0] idxQ;
  logic [pfcs_pkg::CNT_W-1:0] cntQ;
  logic [7:0] dqSync1Q;
  logic [7:0] dqSync2Q;
  logic [7:0] rdDataQ;
  logic prevTogQ;
  logic firstPollQ;
  logic [1:0] stableCntQ;
  logic [pfcs_pkg::TIMER_W-1:0] timerQ;
  logic [pfcs_pkg::TIMER_W-1:0] timeLimit;
  logic timedOut;
  logic lastWrite;
  logic [26:0] nextWord;

  // pin data comes from another timing domain, so two stages first
  always_ff @(posedge clk_sys) begin
    dqSync1Q <= flashDqIn;
    dqSync2Q <= dqSync1Q;
  end

  // operation timer runs from the last write release; a hung flash ends in error
  assign timeLimit = (opQ == pfcs_pkg::OP_PROGRAM) ?
    pfcs_pkg::TIMER_W'(pfcs_pkg::PROG_TIMEOUT_CYC) : pfcs_pkg::TIMER_W'(EraseTimeoutCyc);
  assign timedOut = (timerQ >= timeLimit);
  always_ff @(posedge clk_sys) begin
    if (reset || stateQ == pfcs_pkg::ST_IDLE || stateQ == pfcs_pkg::ST_WREL) begin
      timerQ <= '0;
    end else if (!timedOut) begin
      timerQ <= timerQ + 1'b1;
    end
  end

  assign lastWrite = (idxQ + 3'h1 >= pfcs_pkg::pfcs_seq_len(opQ));
  assign nextWord = pfcs_pkg::pfcs_seq_word(opQ, idxQ + 3'h1, addrQ, dataQ);

  // command sequencer and pin drive
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stateQ <= pfcs_pkg::ST_IDLE;
      opQ <= pfcs_pkg::OP_READ;
      rdKindQ <= pfcs_pkg::RD_USER;
      addrQ <= '0;
      dataQ <= '0;
      idxQ <= '0;
      cntQ <= '0;
      rdDataQ <= '0;
      prevTogQ <= 1'b0;
      firstPollQ <= 1'b0;
      stableCntQ <= '0;
      cmdReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= '0;
      rspError <= 1'b0;
      flashCeN <= 1'b1;
      flashOeN <= 1'b1;
      flashWeN <= 1'b1;
      flashAddr <= '0;
      flashDqOut <= '0;
      flashDqOe <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      case (stateQ)
        pfcs_pkg::ST_IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            // busy until the answer, so nothing reaches a flash that is working
            cmdReady <= 1'b0;
            opQ <= pfcs_pkg::pfcs_op_t'(cmdOp);
            addrQ <= cmdAddr;
            dataQ <= cmdData;
            idxQ <= '0;
            flashCeN <= 1'b0;
            if (pfcs_pkg::pfcs_op_t'(cmdOp) == pfcs_pkg::OP_READ) begin
              rdKindQ <= pfcs_pkg::RD_USER;
              flashAddr <= cmdAddr;
              flashOeN <= 1'b0;
              cntQ <= pfcs_pkg::CNT_W'(pfcs_pkg::RD_WAIT_CYC - 1);
              stateQ <= pfcs_pkg::ST_RLOW;
            end else begin
              {flashAddr, flashDqOut} <= pfcs_pkg::pfcs_seq_word(
                pfcs_pkg::pfcs_op_t'(cmdOp), 3'h0, cmdAddr, cmdData);
              flashDqOe <= 1'b1;
              stateQ <= pfcs_pkg::ST_WSET;
            end
          end
        end
        pfcs_pkg::ST_WSET: begin
          // strobe falls last, after address and chip select have settled
          flashWeN <= 1'b0;
          cntQ <= pfcs_pkg::CNT_W'(pfcs_pkg::WE_LOW_CYC - 1);
          stateQ <= pfcs_pkg::ST_WLOW;
        end
        pfcs_pkg::ST_WLOW: begin
          if (cntQ == '0) begin
            flashWeN <= 1'b1;
            stateQ <= pfcs_pkg::ST_WREL;
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        pfcs_pkg::ST_WREL: begin
          // data held a cycle past the rising strobe before release
          flashCeN <= 1'b1;
          flashDqOe <= 1'b0;
          if (!lastWrite) begin
            idxQ <= idxQ + 3'h1;
            {flashAddr, flashDqOut} <= nextWord;
            flashCeN <= 1'b0;
            flashDqOe <= 1'b1;
            stateQ <= pfcs_pkg::ST_WSET;
          end else if (opQ == pfcs_pkg::OP_ID_ENTRY || opQ == pfcs_pkg::OP_ID_EXIT ||
                       opQ == pfcs_pkg::OP_ID_EXIT_LONG) begin
            rspValid <= 1'b1;
            rspError <= 1'b0;
            stateQ <= pfcs_pkg::ST_IDLE;
          end else begin
            // status is valid from the last rising strobe onward
            rdKindQ <= pfcs_pkg::RD_POLL;
            firstPollQ <= 1'b1;
            stableCntQ <= '0;
            flashAddr <= addrQ;
            stateQ <= pfcs_pkg::ST_RREL;
            cntQ <= '0;
          end
        end
        pfcs_pkg::ST_RLOW: begin
          if (cntQ == '0) begin
            rdDataQ <= dqSync2Q;
            flashCeN <= 1'b1;
            flashOeN <= 1'b1;
            stateQ <= pfcs_pkg::ST_RREL;
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        pfcs_pkg::ST_RREL: begin
          // a high cycle between reads keeps each poll a separate read
          cntQ <= pfcs_pkg::CNT_W'(pfcs_pkg::RD_WAIT_CYC - 1);
          case (rdKindQ)
            pfcs_pkg::RD_USER: begin
              rspValid <= 1'b1;
              rspData <= rdDataQ;
              rspError <= 1'b0;
              stateQ <= pfcs_pkg::ST_IDLE;
            end
            pfcs_pkg::RD_POLL: begin
              if (firstPollQ) begin
                firstPollQ <= 1'b0;
              end else if (rdDataQ[pfcs_pkg::TOGGLE_BIT] != prevTogQ) begin
                stableCntQ <= '0;
              end else begin
                stableCntQ <= stableCntQ + 2'h1;
              end
              prevTogQ <= rdDataQ[pfcs_pkg::TOGGLE_BIT];
              // one stable result plus two confirming rereads
              if (!firstPollQ && rdDataQ[pfcs_pkg::TOGGLE_BIT] == prevTogQ &&
                  stableCntQ == 2'(pfcs_pkg::POLL_CONFIRM - 1)) begin
                rdKindQ <= pfcs_pkg::RD_FINAL;
                if (opQ == pfcs_pkg::OP_PROGRAM) begin
                  cntQ <= pfcs_pkg::CNT_W'(pfcs_pkg::SETTLE_CYC - 1);
                  stateQ <= pfcs_pkg::ST_SETTLE;
                end else begin
                  flashCeN <= 1'b0;
                  flashOeN <= 1'b0;
                  stateQ <= pfcs_pkg::ST_RLOW;
                end
              end else if (timedOut) begin
                rspValid <= 1'b1;
                rspData <= rdDataQ;
                rspError <= 1'b1;
                stateQ <= pfcs_pkg::ST_IDLE;
              end else begin
                flashCeN <= 1'b0;
                flashOeN <= 1'b0;
                stateQ <= pfcs_pkg::ST_RLOW;
              end
            end
            default: begin
              // programmed byte reads true, erased byte all ones; an unerased target fails here
              rspValid <= 1'b1;
              rspData <= rdDataQ;
              rspError <= (opQ == pfcs_pkg::OP_PROGRAM) ? (rdDataQ != dataQ) :
                          (rdDataQ != pfcs_pkg::ERASED_BYTE);
              stateQ <= pfcs_pkg::ST_IDLE;
            end
          endcase
        end
        pfcs_pkg::ST_SETTLE: begin
          if (cntQ == '0) begin
            flashCeN <= 1'b0;
            flashOeN <= 1'b0;
            cntQ <= pfcs_pkg::CNT_W'(pfcs_pkg::RD_WAIT_CYC - 1);
            stateQ <= pfcs_pkg::ST_RLOW;
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        default: stateQ <= pfcs_pkg::ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence weLowPulse;
    $fell(flashWeN) ##1 !flashWeN ##1 flashWeN;
  endsequence
  sequence firstProgWrite;
    $fell(flashWeN) && opQ == pfcs_pkg::OP_PROGRAM && idxQ == 3'h0;
  endsequence

  we_no_oe_a: assert property (!flashWeN |-> flashOeN && !flashCeN)
    else $error("write strobe low without chip select or with output gate low");
  read_no_drive_a: assert property (!flashOeN |-> !flashDqOe)
    else $error("host drives data while flash output gate is low");
  we_pulse_width_a: assert property ($fell(flashWeN) |-> weLowPulse)
    else $error("write strobe pulse is not two cycles");
  write_hold_a: assert property (!flashWeN |-> $stable(flashAddr) &&
    $stable(flashDqOut) && flashDqOe)
    else $error("address or data moved during write strobe");
  data_hold_a: assert property ($rose(flashWeN) |-> $stable(flashDqOut) && flashDqOe)
    else $error("data not held at rising write strobe");
  prog_unlock_a: assert property (firstProgWrite |->
    flashAddr[14:0] == 15'h5555 && flashDqOut == 8'haa)
    else $error("program sequence does not open with unlock write");
  sector_code_a: assert property ($fell(flashWeN) &&
    opQ == pfcs_pkg::OP_SECTOR_ERASE && idxQ == 3'h5 |->
    flashDqOut == 8'h30 && flashAddr[11:0] == 12'h000)
    else $error("sector erase last write wrong");
  busy_no_cmd_a: assert property (cmdValid && cmdReady |=> !cmdReady [*2])
    else $error("command accepted while sequence in progress");
  // a program poll that is not yet the confirming one must end in error once time is up
  prog_timeout_a: assert property (timedOut && opQ == pfcs_pkg::OP_PROGRAM &&
    stateQ == pfcs_pkg::ST_RREL && rdKindQ == pfcs_pkg::RD_POLL && (firstPollQ ||
    rdDataQ[pfcs_pkg::TOGGLE_BIT] != prevTogQ ||
    stableCntQ != 2'(pfcs_pkg::POLL_CONFIRM - 1)) |=> rspValid && rspError)
    else $error("program overrun not reported");
  settle_wait_a: assert property ($rose(stateQ == pfcs_pkg::ST_SETTLE) |->
    (stateQ == pfcs_pkg::ST_SETTLE) [*8])
    else $error("settle wait cut short");

endmodule : pfcs_host

// ==== dv/pfcs_flash_model.sv ====
`timescale 1ns/100ps
// behavioural flash part, no clock: everything follows the strobe pins
module pfcs_flash_model #(
  parameter int ProgNs = 4000,
  parameter int EraseNs = 20000,
  parameter logic [7:0] MakerId = 8'h3c, // arbitrary value
  parameter logic [7:0] PartId = 8'h5a // arbitrary value
) (
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [18:0] addr,
  input wire logic [7:0] dIn,
  output logic [7:0] dOut
);
  logic [7:0] mem [int];
  logic [7:0] target = 8'hff;
  logic [7:0] rdVal = 8'h00;
  logic [18:0] aLat = 19'h00000;
  logic isProg = 1'b0;
  logic idMode = 1'b0;
  logic tog = 1'b0;
  int step = 0;
  int nWr = 0;
  time tFall = 0;
  time opEnd = 0;
  wire wrN = ceN | weN;
  wire rdN = ceN | oeN;
  function automatic logic [7:0] memRd(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : memRd
  task automatic startOp(input logic p, input logic [7:0] t, input int ns);
    isProg = p;
    target = t;
    opEnd = $time + ns;
  endtask : startOp
  // unlock decoder; any wrong word drops back to read mode
  task automatic seqStep(input logic [18:0] a, input logic [7:0] d);
    logic u1;
    logic u2;
    u1 = a[14:0] == 15'h5555;
    u2 = a[14:0] == 15'h2aaa;
    case (step)
      0: begin
        step = (u1 && d == 8'haa) ? 1 : 0;
        if (d == 8'hf0) idMode = 1'b0;
      end
      1, 4: step = (u2 && d == 8'h55) ? step + 1 : 0;
      2: begin
        step = (u1 && d == 8'h80) ? 3 : (u1 && d == 8'ha0) ? 6 : 0;
        if (u1 && d == 8'h90) idMode = 1'b1;
        if (u1 && d == 8'hf0) idMode = 1'b0;
      end
      3: step = (u1 && d == 8'haa) ? 4 : 0;
      5: begin
        if (d == 8'h30) begin
          foreach (mem[k]) if (k[18:12] == a[18:12]) mem[k] = 8'hff;
          startOp(1'b0, 8'hff, EraseNs);
        end else if (u1 && d == 8'h10) begin
          mem.delete();
          startOp(1'b0, 8'hff, EraseNs);
        end
        step = 0;
      end
      default: begin
        mem[a] = memRd(a) & d;
        startOp(1'b1, d, ProgNs);
        step = 0;
      end
    endcase
  endtask : seqStep
  // address on the later falling strobe
  always @(negedge wrN) begin
    aLat = addr;
    tFall = $time;
  end
  // data on the earlier rising strobe; glitches and gated writes start nothing
  always @(posedge wrN) begin
    if (oeN && $time - tFall >= 5) begin
      nWr++;
      if ($time >= opEnd) seqStep(aLat, dIn);
    end
  end
  // status while busy; low bits lag for a while after a program
  always @(negedge rdN) begin
    if ($time < opEnd) tog = ~tog;
    if ($time < opEnd) rdVal = {isProg ? ~target[7] : 1'b0, tog, target[5:0]};
    else if (idMode && addr[18:1] == 18'h0) rdVal = addr[0] ? PartId : MakerId;
    else rdVal = memRd(addr);
    if (isProg && $time >= opEnd && $time < opEnd + 1000) rdVal[5:0] = ~rdVal[5:0];
  end
  // released bus shows the inverse, never a stale match
  assign dOut = rdN ? ~rdVal : rdVal;
endmodule : pfcs_flash_model

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  localparam logic [7:0] MakerCode = 8'h3c; // arbitrary value
  localparam logic [7:0] PartCode = 8'h5a; // arbitrary value
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cmdValid = 1'b0;
  logic [2:0] cmdOp = 3'h0;
  logic [18:0] cmdAddr = 19'h00000;
  logic [7:0] cmdData = 8'h00;
  logic cmdReady, rspValid, rspError, flashCeN, flashOeN, flashWeN, flashDqOe, err;
  logic [7:0] rspData, flashDqOut, modelOut, got;
  logic [18:0] flashAddr;
  int failures = 0;
  int checked = 0;
  // wire level: the host wins while it drives
  wire [7:0] dqLine = flashDqOe ? flashDqOut : modelOut;
  always #20 clk_sys = ~clk_sys;
  pfcs_host #(.EraseTimeoutCyc(2000)) uut (.clk_sys(clk_sys), .reset(reset),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspError(rspError),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(dqLine));
  pfcs_flash_model #(.MakerId(MakerCode), .PartId(PartCode)) fm (.ceN(flashCeN),
    .oeN(flashOeN), .weN(flashWeN), .addr(flashAddr), .dIn(dqLine), .dOut(modelOut));
  task automatic results;
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // a write strobe only falls with chip select low and output gate high
  always @(negedge flashWeN) if (!reset) `CHK({flashCeN, flashOeN, flashDqOe}, 3'h3)
  // one command, bounded waits for take and answer, then the write count
  task automatic cmd(input logic [2:0] op, input logic [18:0] a, input int nExp);
    int i;
    int w0;
    w0 = fm.nWr;
    cmdOp <= op;
    cmdAddr <= a;
    cmdValid <= 1'b1;
    i = 0;
    do begin @(posedge clk_sys); i++; end while (cmdReady !== 1'b1 && i < 50);
    cmdValid <= 1'b0;
    // a command never taken skips the answer wait and counts as a failure
    if (cmdReady !== 1'b1) i = 5000;
    else i = 0;
    while (rspValid !== 1'b1 && i < 5000) begin
      @(posedge clk_sys);
      i++;
    end
    if (rspValid !== 1'b1) begin
      failures++;
      results();
    end else begin
      got = rspData;
      err = rspError;
      `CHK(fm.nWr - w0, nExp)
    end
  endtask : cmd
  task automatic t_reset;
    `CHK({flashCeN, flashOeN, flashWeN, flashDqOe, cmdReady}, 5'h1c)
  endtask : t_reset
  task automatic t_read;
    cmd(3'h0, 19'h41234, 0);
    `CHK(got, 8'hff)
  endtask : t_read
  // flash only clears bits, so programming over a written byte must fail verify
  task automatic t_program;
    cmdData <= 8'h5a;
    cmd(3'h1, 19'h7a123, 4);
    `CHK({err, got}, 9'h05a)
    cmdData <= 8'hc3;
    cmd(3'h1, 19'h7b000, 4);
    cmd(3'h0, 19'h7a123, 0);
    `CHK(got, 8'h5a)
    cmdData <= 8'h3c;
    cmd(3'h1, 19'h7b000, 4);
    `CHK(err, 1'b1)
  endtask : t_program
  // sector erase reaches its own 4 KByte sector and no other
  task automatic t_sector;
    cmd(3'h2, 19'h7a800, 6);
    `CHK({err, got}, 9'h0ff)
    cmd(3'h0, 19'h7a123, 0);
    `CHK(got, 8'hff)
    cmd(3'h0, 19'h7b000, 0);
    `CHK(got, 8'h00)
  endtask : t_sector
  task automatic t_chip;
    cmd(3'h3, 19'h00000, 6);
    `CHK({err, got}, 9'h0ff)
    cmd(3'h0, 19'h7b000, 0);
    `CHK(got, 8'hff)
  endtask : t_chip
  // codes show only between entry and either form of exit
  task automatic t_ident;
    cmd(3'h4, 19'h00000, 3);
    cmd(3'h0, 19'h00000, 0);
    `CHK(got, MakerCode)
    cmd(3'h0, 19'h00001, 0);
    `CHK(got, PartCode)
    cmd(3'h5, 19'h12345, 1);
    cmd(3'h0, 19'h00000, 0);
    `CHK(got, 8'hff)
    cmd(3'h4, 19'h00000, 3);
    cmd(3'h6, 19'h00000, 3);
    cmd(3'h0, 19'h00001, 0);
    `CHK(got, 8'hff)
  endtask : t_ident
  initial begin
    repeat (20) @(posedge clk_sys);
    t_reset();
    reset <= 1'b0;
    @(posedge clk_sys);
    t_read();
    t_program();
    t_sector();
    t_chip();
    t_ident();
    results();
  end
endmodule : testbench
